// file: hdl/cef_flag_bank_map.vh
// register offsets, field positions and reset values of the flag bank
`ifndef CEF_FLAG_BANK_MAP_VH
`define CEF_FLAG_BANK_MAP_VH

// register offsets on the byte register port
`define CEF_ADDR_ANALOG_FLAGS    8'h05
`define CEF_ADDR_FAULT_FLAGS     8'h06
`define CEF_ADDR_CHG_MASK        8'h07
`define CEF_ADDR_FAULT_MASK      8'h08

// reset values
`define CEF_RST_ANALOG_FLAGS     8'h00
`define CEF_RST_FAULT_FLAGS      8'h00
`define CEF_RST_CHG_MASK         8'h00
`define CEF_RST_FAULT_MASK       8'h00
`define CEF_RDATA_UNMAPPED       8'h00

// bits that can ever hold a one (reserved bits read zero)
`define CEF_LIVE_ANALOG_FLAGS    8'hF1
`define CEF_LIVE_FAULT_FLAGS     8'h77
`define CEF_LIVE_CHG_MASK        8'h7F
`define CEF_LIVE_FAULT_MASK      8'hBF

// analog event flag fields
`define CEF_CONV_DONE_BIT        7
`define CEF_CMP_ONE_BIT          6
`define CEF_CMP_TWO_BIT          5
`define CEF_CMP_THREE_BIT        4
`define CEF_THERM_OPEN_BIT       0

// fault and timer event flag fields
`define CEF_WATCHDOG_BIT         6
`define CEF_SAFETY_BIT           5
`define CEF_AUX_OCP_BIT          4
`define CEF_WAKE_FIRST_BIT       2
`define CEF_WAKE_SECOND_BIT      1
`define CEF_RESET_WARN_BIT       0

// charger-state mask fields
`define CEF_CONSTANT_VOLTAGE_ENTRY_GATE  6
`define CEF_CHARGE_DONE_GATE             5
`define CEF_INPUT_CURRENT_LIMIT_GATE     4
`define CEF_POWER_PATH_LIMIT_GATE        3
`define CEF_INPUT_VOLTAGE_LIMIT_GATE     2
`define CEF_THERMAL_REGULATION_GATE      1
`define CEF_INPUT_POWER_GOOD_GATE        0

// fault mask fields
`define CEF_INPUT_OVERVOLTAGE_GATE       7
`define CEF_BATTERY_OVERCURRENT_GATE     5
`define CEF_BATTERY_UNDERVOLTAGE_GATE    4
`define CEF_TEMP_REGION_FRIGID_GATE      3
`define CEF_TEMP_REGION_CHILLY_GATE      2
`define CEF_TEMP_REGION_MILD_HOT_GATE    1
`define CEF_TEMP_REGION_OVERHEAT_GATE    0

// widths
`define CEF_REG_W                8
`define CEF_MEAS_W               16
`define CEF_CMP_N                3

`endif

// file: hdl/cef_sticky8.v
// one byte of sticky event flags, cleared as a whole on read
`timescale 1ns/1ps
module cef_sticky8 #(
    parameter [7:0] RESET_VALUE = 8'h00,  // value after reset
    parameter [7:0] LIVE_BITS   = 8'hFF   // bits that may ever set
) (
    // clock and reset
    input  wire       mclk,
    input  wire       resetn,
    // event side
    input  wire [7:0] set_vec,      // one-cycle set requests per bit
    // register side
    input  wire       clear_all,    // read strobe of this register
    output reg  [7:0] flags_r       // latched flags
);

    reg [7:0] flags_nxt;  // next flag value

    // clear first, then or in the sets so a set never gets lost
    always @* begin
        flags_nxt = flags_r;
        if (clear_all) begin
            flags_nxt = 8'h00;
        end
        flags_nxt = (flags_nxt | set_vec) & LIVE_BITS;
    end

    // flag storage
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flags_r <= RESET_VALUE;
        end else begin
            flags_r <= flags_nxt;
        end
    end

endmodule

// file: hdl/cef_flag_bank.v
// event flag and interrupt mask register bank of the charge manager
// What this block does
// - analog flags at 0x5, reset zero, clear-on-read
// - fault/timer flags at 0x6, reset zero, clear-on-read
// - bit 7 sets on completed conversion
// - bits 6-4 set on comparator crossing
// - bit 0 thermistor open; bits 3-1 zero
// - bit 6 sets on watchdog expiry
// - bit 5 sets on safety timer expiry
// - bit 4 sets on regulator overcurrent
// - bits 2,1 set on wake timers
// - bit 0 reset warning; bits 7,3 reserved
// - charger-state mask at 0x7, bit 7 reserved
// - mask bits 6-0 gate charger events
// - fault mask at 0x8, bit 7 overvoltage
// - bits 5-0 gate battery and temperature events
// - mask one suppresses the interrupt
// - mask zero lets the interrupt through
// - direction picks above/below; live status shown
`timescale 1ns/1ps
`include "cef_flag_bank_map.vh"
module cef_flag_bank (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,

    // byte register port from the serial host interface
    input  wire [7:0]  reg_addr,
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_r,
    output reg         reg_rvalid_r,

    // converter events
    input  wire        conversion_done,
    input  wire        sample_valid,
    input  wire [15:0] comparator_one_measure,
    input  wire [15:0] comparator_two_measure,
    input  wire [15:0] comparator_three_measure,
    input  wire [15:0] comparator_one_threshold,
    input  wire [15:0] comparator_two_threshold,
    input  wire [15:0] comparator_three_threshold,
    input  wire        comparator_one_direction,
    input  wire        comparator_two_direction,
    input  wire        comparator_three_direction,
    input  wire        thermistor_open,

    // fault and timer events
    input  wire        host_watchdog_expired,
    input  wire        charge_safety_expired,
    input  wire        aux_regulator_overcurrent,
    input  wire        button_wake_first_expired,
    input  wire        button_wake_second_expired,
    input  wire        button_reset_warning_expired,

    // flags and masks held in neighbouring register banks
    input  wire [7:0]  charger_state_flags,
    input  wire [7:0]  fault_flags,
    input  wire [7:0]  analog_event_mask,
    input  wire [7:0]  fault_timer_event_mask,

    // state shown to the rest of the device
    output reg  [2:0]  comparator_status_r,
    output reg  [7:0]  charger_state_irq_mask_r,
    output reg  [7:0]  fault_irq_mask_r,
    output reg         irq_req_r
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    wire [7:0]  analog_event_flags;       // latched analog flags
    wire [7:0]  fault_timer_event_flags;  // latched fault flags
    reg  [7:0]  analog_set;               // analog set requests
    reg  [7:0]  fault_set;                // fault set requests
    reg         therm_open_prev_r;        // last thermistor level
    reg         aux_ocp_prev_r;           // last regulator level
    wire [47:0] meas_bus;                 // packed measurements
    wire [47:0] thr_bus;                  // packed thresholds
    wire [2:0]  dir_bus;                  // packed directions
    wire [2:0]  cmp_cond;                 // condition now holding
    wire [2:0]  cmp_cross;                // fresh crossing events
    reg  [2:0]  comparator_status_nxt;    // next live status
    wire        rd_analog;                // read of analog flags
    wire        rd_fault;                 // read of fault flags
    wire        wr_chg_mask;              // write of charger mask
    wire        wr_fault_mask;            // write of fault mask
    reg  [7:0]  reg_rdata_nxt;            // read mux result
    reg  [7:0]  chg_mask_nxt;             // next charger mask
    reg  [7:0]  fault_mask_nxt;           // next fault mask
    wire        irq_nxt;                  // any unmasked flag

    // ------------------------------------------------------------
    // address decode, used by both the read and write paths
    // ------------------------------------------------------------
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // strobes of the four registers
    assign rd_analog     = reg_rd & addr_hit(reg_addr,
                                             `CEF_ADDR_ANALOG_FLAGS);
    assign rd_fault      = reg_rd & addr_hit(reg_addr,
                                             `CEF_ADDR_FAULT_FLAGS);
    assign wr_chg_mask   = reg_wr & addr_hit(reg_addr,
                                             `CEF_ADDR_CHG_MASK);
    assign wr_fault_mask = reg_wr & addr_hit(reg_addr,
                                             `CEF_ADDR_FAULT_MASK);

    // ------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------
    // pack the per-comparator ports so one loop serves all three
    assign meas_bus = {comparator_three_measure,
                       comparator_two_measure,
                       comparator_one_measure};
    assign thr_bus  = {comparator_three_threshold,
                       comparator_two_threshold,
                       comparator_one_threshold};
    assign dir_bus  = {comparator_three_direction,
                       comparator_two_direction,
                       comparator_one_direction};

    // direction one wants above the threshold, zero wants below;
    // equal to the threshold never counts, so a value parked on
    // the threshold cannot chatter the flag
    genvar gi;
    generate
        for (gi = 0; gi < `CEF_CMP_N; gi = gi + 1) begin : g_cmp
            wire [15:0] meas;
            wire [15:0] thr;
            assign meas = meas_bus[gi*`CEF_MEAS_W +: `CEF_MEAS_W];
            assign thr  = thr_bus[gi*`CEF_MEAS_W +: `CEF_MEAS_W];
            assign cmp_cond[gi] = dir_bus[gi] ? (meas > thr)
                                              : (meas < thr);
            // a crossing is the step from not holding to holding
            assign cmp_cross[gi] = sample_valid & cmp_cond[gi] &
                                   ~comparator_status_r[gi];
        end
    endgenerate

    // live status follows each new sample only
    always @* begin
        comparator_status_nxt = comparator_status_r;
        if (sample_valid) begin
            comparator_status_nxt = cmp_cond;
        end
    end

    // status and level history
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            comparator_status_r <= 3'b000;
            therm_open_prev_r   <= 1'b0;
            aux_ocp_prev_r      <= 1'b0;
        end else begin
            comparator_status_r <= comparator_status_nxt;
            therm_open_prev_r   <= thermistor_open;
            aux_ocp_prev_r      <= aux_regulator_overcurrent;
        end
    end

    // ------------------------------------------------------------
    // set requests of the analog event flags
    // ------------------------------------------------------------
    // levels are edge-detected: a fault that persists sets the
    // flag once and does not refill it after every clearing read
    always @* begin
        analog_set = `CEF_RST_ANALOG_FLAGS;
        analog_set[`CEF_CONV_DONE_BIT] = conversion_done;
        analog_set[`CEF_CMP_ONE_BIT]   = cmp_cross[0];
        analog_set[`CEF_CMP_TWO_BIT]   = cmp_cross[1];
        analog_set[`CEF_CMP_THREE_BIT] = cmp_cross[2];
        analog_set[`CEF_THERM_OPEN_BIT] =
            thermistor_open & ~therm_open_prev_r;
    end

    // ------------------------------------------------------------
    // set requests of the fault and timer event flags
    // ------------------------------------------------------------
    // timers arrive as one-cycle expiry pulses; reserved bits
    // 7 and 3 have no source and stay zero
    always @* begin
        fault_set = `CEF_RST_FAULT_FLAGS;
        fault_set[`CEF_WATCHDOG_BIT]    = host_watchdog_expired;
        fault_set[`CEF_SAFETY_BIT]      = charge_safety_expired;
        fault_set[`CEF_AUX_OCP_BIT]     =
            aux_regulator_overcurrent & ~aux_ocp_prev_r;
        fault_set[`CEF_WAKE_FIRST_BIT]  = button_wake_first_expired;
        fault_set[`CEF_WAKE_SECOND_BIT] =
            button_wake_second_expired;
        fault_set[`CEF_RESET_WARN_BIT]  =
            button_reset_warning_expired;
    end

    // ------------------------------------------------------------
    // the two clear-on-read flag bytes
    // ------------------------------------------------------------
    // analog event flags
    cef_sticky8 #(
        .RESET_VALUE (`CEF_RST_ANALOG_FLAGS),
        .LIVE_BITS   (`CEF_LIVE_ANALOG_FLAGS)
    ) u_analog_flags (
        .mclk      (mclk),
        .resetn    (resetn),
        .set_vec   (analog_set),
        .clear_all (rd_analog),
        .flags_r   (analog_event_flags)
    );

    // fault and timer event flags
    cef_sticky8 #(
        .RESET_VALUE (`CEF_RST_FAULT_FLAGS),
        .LIVE_BITS   (`CEF_LIVE_FAULT_FLAGS)
    ) u_fault_flags (
        .mclk      (mclk),
        .resetn    (resetn),
        .set_vec   (fault_set),
        .clear_all (rd_fault),
        .flags_r   (fault_timer_event_flags)
    );

    // ------------------------------------------------------------
    // mask registers
    // ------------------------------------------------------------
    // reserved bits are not stored, so they always read zero
    always @* begin
        chg_mask_nxt   = charger_state_irq_mask_r;
        fault_mask_nxt = fault_irq_mask_r;
        if (wr_chg_mask) begin
            chg_mask_nxt = reg_wdata & `CEF_LIVE_CHG_MASK;
        end
        if (wr_fault_mask) begin
            fault_mask_nxt = reg_wdata & `CEF_LIVE_FAULT_MASK;
        end
    end

    // mask storage
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            charger_state_irq_mask_r <= `CEF_RST_CHG_MASK;
            fault_irq_mask_r         <= `CEF_RST_FAULT_MASK;
        end else begin
            charger_state_irq_mask_r <= chg_mask_nxt;
            fault_irq_mask_r         <= fault_mask_nxt;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // flags are returned as they stood before the clearing edge;
    // an unmapped offset reads zero and has no side effect
    always @* begin
        case (1'b1)
            rd_analog: begin
                reg_rdata_nxt = analog_event_flags;
            end
            rd_fault: begin
                reg_rdata_nxt = fault_timer_event_flags;
            end
            reg_rd & addr_hit(reg_addr, `CEF_ADDR_CHG_MASK): begin
                reg_rdata_nxt = charger_state_irq_mask_r;
            end
            reg_rd & addr_hit(reg_addr, `CEF_ADDR_FAULT_MASK): begin
                reg_rdata_nxt = fault_irq_mask_r;
            end
            default: begin
                reg_rdata_nxt = `CEF_RDATA_UNMAPPED;
            end
        endcase
    end

    // read data holds until the next read
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata_r  <= `CEF_RDATA_UNMAPPED;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_rd;
            if (reg_rd) begin
                reg_rdata_r <= reg_rdata_nxt;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------
    // a set mask bit blocks its flag, a clear one passes it;
    // the reserved bits of both mask registers are held at zero, and the
    // flags they would gate never set, so they cannot leak
    assign irq_nxt =
        |(charger_state_flags & ~charger_state_irq_mask_r) |
        |(fault_flags & ~fault_irq_mask_r) |
        |(analog_event_flags & ~analog_event_mask) |
        |(fault_timer_event_flags & ~fault_timer_event_mask);

    // request is registered: one cycle behind the flags
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irq_req_r <= 1'b0;
        end else begin
            irq_req_r <= irq_nxt;
        end
    end

endmodule

// file: tb/cef_flag_bank_checker.sv
// port assertions for the event flag and mask register bank
`timescale 1ns/1ps
module cef_flag_bank_checker (
    // clock and reset
    input wire logic       mclk,
    input wire logic       resetn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic       reg_rd,
    input wire logic       reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       reg_rvalid_r,
    // event and interrupt side
    input wire logic       host_watchdog_expired,
    input wire logic [7:0] fault_timer_event_mask,
    input wire logic [7:0] charger_state_flags,
    input wire logic [7:0] fault_flags,
    input wire logic [7:0] charger_state_irq_mask_r,
    input wire logic [7:0] fault_irq_mask_r,
    input wire logic       irq_req_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // watchdog pulse with its gate open over two edges
    sequence wd_open_s;
        host_watchdog_expired && !fault_timer_event_mask[6]
            ##1 !fault_timer_event_mask[6];
    endsequence

    read_answer_a: assert property (reg_rd |=> reg_rvalid_r)
        else $error("read not answered next cycle");
    answer_pulse_a: assert property (!reg_rd |=> !reg_rvalid_r)
        else $error("answer without read");
    chg_mask_wr_a: assert property (reg_wr && reg_addr == 8'h07 |=>
        charger_state_irq_mask_r == ($past(reg_wdata) & 8'h7F))
        else $error("charger mask write wrong");
    fault_mask_wr_a: assert property (reg_wr && reg_addr == 8'h08 |=>
        fault_irq_mask_r == ($past(reg_wdata) & 8'hBF))
        else $error("fault mask write wrong");
    mask_read_a: assert property (reg_rd && !reg_wr &&
        reg_addr == 8'h08 |=> reg_rdata_r == $past(fault_irq_mask_r))
        else $error("fault mask read wrong");
    unmapped_zero_a: assert property (reg_rd &&
        (reg_addr < 8'h05 || reg_addr > 8'h08) |=> reg_rdata_r == 8'h00)
        else $error("unmapped read not zero");
    analog_resv_a: assert property (reg_rd && reg_addr == 8'h05 |=>
        reg_rdata_r[3:1] == 3'b000)
        else $error("analog reserved bits set");
    fault_resv_a: assert property (reg_rd && reg_addr == 8'h06 |=>
        !reg_rdata_r[7] && !reg_rdata_r[3])
        else $error("fault reserved bits set");
    chg_irq_a: assert property (|(charger_state_flags &
        ~charger_state_irq_mask_r & 8'h7F) |=> irq_req_r)
        else $error("unmasked charger flag gave no irq");
    fault_irq_a: assert property (|(fault_flags &
        ~fault_irq_mask_r & 8'hBF) |=> irq_req_r)
        else $error("unmasked fault flag gave no irq");
    wd_irq_a: assert property (wd_open_s |=> irq_req_r)
        else $error("watchdog expiry gave no irq");
endmodule

bind cef_flag_bank cef_flag_bank_checker chk_u (
    .mclk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
    .reg_rdata_r, .reg_rvalid_r, .host_watchdog_expired,
    .fault_timer_event_mask, .charger_state_flags, .fault_flags,
    .charger_state_irq_mask_r, .fault_irq_mask_r, .irq_req_r
);

// file: tb/cef_host_model.sv
// host side of the byte register port, one access per call
`timescale 1ns/1ps
module cef_host_model (
    // clock
    input  wire logic       mclk,
    // register port
    output logic      [7:0] reg_addr,
    output logic            reg_rd,
    output logic            reg_wr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata_r
);
    // idle port from time zero
    initial begin
        reg_addr  = 8'h00;
        reg_rd    = 1'b0;
        reg_wr    = 1'b0;
        reg_wdata = 8'h00;
    end

    // write held over one rising edge; lines scrambled once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge mclk);
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
        @(negedge mclk);
    endtask

    // read data taken in the one cycle the answer stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr = a;
        reg_rd   = 1'b1;
        @(negedge mclk);
        d        = reg_rdata_r;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(negedge mclk);
    endtask
endmodule

// file: tb/cef_flag_bank_bench.sv
// self-checking bench for the event flag and mask register bank
`timescale 1ns/1ps
module cef_flag_bank_bench;
    logic        mclk = 1'b0;            // 10 MHz device clock
    logic        resetn = 1'b0;          // device reset, active low
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, d;
    logic        reg_rd, reg_wr, reg_rvalid_r, irq_req_r;
    logic        conversion_done = 1'b0;
    logic        sample_valid = 1'b0;
    logic        thermistor_open = 1'b0;
    logic [15:0] meas = 16'h0000;        // one measurement for all three
    logic [15:0] thr = 16'h0100;         // one threshold for all three
    logic [2:0]  dir = 3'b000;           // directions, bit0 = comparator one
    logic [5:0]  fev = 6'h00;            // timer and fault event sources
    logic [7:0]  charger_state_flags = 8'h00, fault_flags = 8'h00;
    logic [7:0]  analog_event_mask = 8'h00, fault_timer_event_mask = 8'h00;
    logic [2:0]  comparator_status_r;
    logic [7:0]  charger_state_irq_mask_r, fault_irq_mask_r;
    int          failures = 0, n_tests = 0, cycles = 0, i;

    always #50 mclk = ~mclk;

    cef_host_model host_u (
        .mclk, .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata_r
    );
    cef_flag_bank dut_u (
        .mclk, .resetn, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
        .reg_rdata_r, .reg_rvalid_r, .conversion_done, .sample_valid,
        .comparator_one_measure(meas), .comparator_two_measure(meas),
        .comparator_three_measure(meas), .comparator_one_threshold(thr),
        .comparator_two_threshold(thr), .comparator_three_threshold(thr),
        .comparator_one_direction(dir[0]), .comparator_two_direction(dir[1]),
        .comparator_three_direction(dir[2]), .thermistor_open,
        .host_watchdog_expired(fev[5]), .charge_safety_expired(fev[4]),
        .aux_regulator_overcurrent(fev[3]),
        .button_wake_first_expired(fev[2]),
        .button_wake_second_expired(fev[1]),
        .button_reset_warning_expired(fev[0]),
        .charger_state_flags, .fault_flags, .analog_event_mask,
        .fault_timer_event_mask, .comparator_status_r,
        .charger_state_irq_mask_r, .fault_irq_mask_r, .irq_req_r
    );

    // counts and verdict, the single end of the run
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // compare and report
    task automatic chk(input string s, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", s, e, g);
        end
    endtask

    task automatic rdx(input logic [7:0] a, e, input string s);
        logic [7:0] v;
        host_u.rd(a, v);
        chk(s, e, v);
    endtask

    // one-cycle source pulse, index into the event vector
    task automatic pulse(input int k);
        fev[k] = 1'b1;
        @(negedge mclk);
        fev[k] = 1'b0;
    endtask

    task automatic sample();
        sample_valid = 1'b1;
        @(negedge mclk);
        sample_valid = 1'b0;
    endtask

    // open one gate, then shut it; other mask stays all ones
    task automatic gate(input logic [7:0] a, input int b);
        logic [7:0] m;
        m = 8'h01 << b;
        host_u.wr(a, ~m);
        if (a == 8'h07) charger_state_flags = m;
        else fault_flags = m;
        repeat (2) @(negedge mclk);
        chk("irq open", 8'h01, {7'h00, irq_req_r});
        host_u.wr(a, 8'hFF);
        @(negedge mclk);
        chk("irq gated", 8'h00, {7'h00, irq_req_r});
        charger_state_flags = 8'h00;
        fault_flags = 8'h00;
    endtask

    // hang guard, far above the 175 cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            test_done();
        end
    end

    initial begin
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        // reset values, then one unmapped offset
        for (i = 5; i <= 9; i++)
            rdx(i[7:0], 8'h00, "reset value");
        // each timer and fault source, then clear on read
        for (i = 0; i < 6; i++) begin
            pulse(i);
            rdx(8'h06, 8'h01 << ((i < 3) ? i : i + 1), "fault flag");
            rdx(8'h06, 8'h00, "fault clear");
        end
        thermistor_open = 1'b1;
        conversion_done = 1'b1;
        @(negedge mclk);
        conversion_done = 1'b0;
        rdx(8'h05, 8'h81, "ready and open");
        rdx(8'h05, 8'h00, "analog clear");
        meas = 16'h0200;
        dir = 3'b111;
        sample();
        chk("comparator status", 8'h07, {5'h00, comparator_status_r});
        rdx(8'h05, 8'h70, "above crossing");
        dir = 3'b000;
        sample();
        meas = 16'h0080;
        sample();
        rdx(8'h05, 8'h70, "below crossing");
        // mask storage, reserved bits and read-only flags
        host_u.wr(8'h07, 8'hFF);
        rdx(8'h07, 8'h7F, "charger mask");
        host_u.wr(8'h08, 8'hFF);
        rdx(8'h08, 8'hBF, "fault mask");
        host_u.wr(8'h05, 8'hFF);
        rdx(8'h05, 8'h00, "flags not writable");
        // every gate of both masks
        for (i = 0; i < 8; i++) begin
            if (i < 7) gate(8'h07, i);
            if (i != 6) gate(8'h08, i);
        end
        // event landing in the cycle of the clearing read
        fork
            pulse(5);
            host_u.rd(8'h06, d);
        join
        chk("read during set", 8'h00, d);
        rdx(8'h06, 8'h40, "set kept");
        // own flags through the masks held outside
        analog_event_mask = 8'hFF;
        fault_timer_event_mask = 8'hBF;
        pulse(5);
        repeat (2) @(negedge mclk);
        chk("own flag irq", 8'h01, {7'h00, irq_req_r});
        fault_timer_event_mask = 8'hFF;
        repeat (2) @(negedge mclk);
        chk("own flag gated", 8'h00, {7'h00, irq_req_r});
        rdx(8'h06, 8'h40, "masked flag kept");
        test_done();
    end
endmodule
